// ==== adc_control_pin_decode.sv ====
// control pin decoder and serial register file of a dual converter
`timescale 1ns/100ps
module adc_control_pin_decode (
   input  wire logic                                   sys_clk,
   input  wire logic                                   rst_n,
   input  wire logic                                   serial_write_clock,
   input  wire adc_pin_pkg::pins_s                     pins,
   input  wire logic [adc_pin_pkg::SAMPLE_BITS-1:0]    sample_a,
   input  wire logic [adc_pin_pkg::SAMPLE_BITS-1:0]    sample_b,
   input  wire logic                                   over_range_raw_a,
   input  wire logic                                   over_range_raw_b,
   input  wire logic [adc_pin_pkg::BUS_ADDR_BITS-1:0]  bus_addr,
   input  wire logic [adc_pin_pkg::BUS_DATA_BITS-1:0]  bus_wdata,
   input  wire logic                                   bus_write,
   input  wire logic                                   bus_read,
   output logic      [adc_pin_pkg::BUS_DATA_BITS-1:0]  bus_rdata,
   output logic      [adc_pin_pkg::SAMPLE_BITS-1:0]    data_a,
   output logic                                        data_a_oe_n,
   output logic      [adc_pin_pkg::SAMPLE_BITS-1:0]    data_b,
   output logic                                        data_b_oe_n,
   output logic                                        power_down,
   output logic                                        internal_reference,
   output logic                                        over_range_flag_a,
   output logic                                        over_range_flag_b,
   output logic                                        serial_mode
);
   import adc_pin_pkg::*;

   // ------------------------------------------------------------
   // format conversion, shared by both channels
   // ------------------------------------------------------------
   // two's complement differs from offset binary only in the msb
   function automatic logic [SAMPLE_BITS-1:0] apply_format(
      input logic [SAMPLE_BITS-1:0] sample,
      input logic                   invert
   );
      apply_format = {sample[SAMPLE_BITS-1] ^ invert, sample[SAMPLE_BITS-2:0]};
   endfunction

   // ------------------------------------------------------------
   // pin and link crossing
   // ------------------------------------------------------------
   pins_s                    sync_pins;
   logic                     sync_toggle;
   logic [SER_WORD_BITS-1:0] link_word;
   logic                     link_toggle;

   pin_sync #(
      .WIDTH ($bits(pins_s) + 1)
   ) u_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in ({pins, link_toggle}),
      .sync_out ({sync_pins, sync_toggle})
   );

   // serial pins are only meaningful with select high
   serial_shift_in u_serial (
      .serial_write_clock    (serial_write_clock),
      .mode_select           (pins.mode_select),
      .serial_write_enable_n (pins.shared_a),
      .serial_write_data     (pins.shared_c),
      .word                  (link_word),
      .word_toggle           (link_toggle)
   );

   // ------------------------------------------------------------
   // mode and serial register file
   // ------------------------------------------------------------
   port_mode_e               mode;
   port_mode_e               next_mode;
   logic [SER_DATA_BITS-1:0] ser_regs [SER_REG_COUNT];
   logic [SER_DATA_BITS-1:0] next_ser_regs [SER_REG_COUNT];
   logic                     toggle_seen;
   logic                     next_toggle_seen;
   logic [SER_ADDR_BITS-1:0] word_addr;
   logic [SER_DATA_BITS-1:0] word_data;

   assign word_addr = link_word[SER_WORD_BITS-1 -: SER_ADDR_BITS];
   assign word_data = link_word[SER_DATA_BITS-1:0];

   always_comb begin
      next_ser_regs    = ser_regs;
      next_toggle_seen = sync_toggle;
      case (mode)
         MODE_DIRECT: next_mode = sync_pins.mode_select ? MODE_SERIAL : MODE_DIRECT;
         MODE_SERIAL: next_mode = sync_pins.mode_select ? MODE_SERIAL : MODE_DIRECT;
         default:     next_mode = MODE_DIRECT;
      endcase
      if (!rst_n || !sync_pins.mode_select) begin
         // select low holds every serial register at default
         for (int i = 0; i < SER_REG_COUNT; i++) begin
            next_ser_regs[i] = SER_REG_RESET;
         end
         next_mode = MODE_DIRECT;
      end else if (sync_toggle != toggle_seen) begin
         // a word is stable in the link hold register until the next 16 clocks
         next_ser_regs[word_addr] = word_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      mode        <= next_mode;
      ser_regs    <= next_ser_regs;
      toggle_seen <= next_toggle_seen;
   end

   // ------------------------------------------------------------
   // effective controls
   // ------------------------------------------------------------
   controls_s                 ctrl;
   logic                      force_pd;
   logic                      next_force_pd;
   logic                      pd_eff;
   logic [SER_DATA_BITS-1:0]  ser_ctrl;

   assign ser_ctrl = ser_regs[SER_CTRL_ADDR];

   always_comb begin
      if (mode == MODE_DIRECT) begin
         ctrl.format_invert      = sync_pins.shared_a;
         ctrl.out_enable_a_n     = sync_pins.shared_b;
         ctrl.power_down_request = sync_pins.shared_c;
      end else begin
         // in serial mode the shared pins carry the port, so the register steers
         ctrl.format_invert      = ser_ctrl[SER_FMT_BIT];
         ctrl.out_enable_a_n     = ser_ctrl[SER_OEA_BIT];
         ctrl.power_down_request = ser_ctrl[SER_PD_BIT];
      end
      pd_eff = ctrl.power_down_request | force_pd;
   end

   // ------------------------------------------------------------
   // output stage
   // ------------------------------------------------------------
   logic [SAMPLE_BITS-1:0] next_data_a;
   logic [SAMPLE_BITS-1:0] next_data_b;
   logic                   next_oe_a_n;
   logic                   next_oe_b_n;
   logic                   next_range_a;
   logic                   next_range_b;

   always_comb begin
      next_data_a  = apply_format(sample_a, ctrl.format_invert);
      next_data_b  = apply_format(sample_b, ctrl.format_invert);
      next_oe_a_n  = ctrl.out_enable_a_n;
      next_oe_b_n  = sync_pins.out_enable_b_n;
      next_range_a = over_range_raw_a;
      next_range_b = over_range_raw_b;
      if (pd_eff) begin
         // a powered-down core makes no samples worth showing
         next_data_a  = '0;
         next_data_b  = '0;
         next_range_a = 1'b0;
         next_range_b = 1'b0;
      end
      if (!rst_n) begin
         next_data_a  = '0;
         next_data_b  = '0;
         next_oe_a_n  = 1'b1;
         next_oe_b_n  = 1'b1;
         next_range_a = 1'b0;
         next_range_b = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      data_a             <= next_data_a;
      data_b             <= next_data_b;
      data_a_oe_n        <= next_oe_a_n;
      data_b_oe_n        <= next_oe_b_n;
      over_range_flag_a  <= next_range_a;
      over_range_flag_b  <= next_range_b;
      power_down         <= rst_n & pd_eff;
      internal_reference <= rst_n & sync_pins.reference_source_select;
      serial_mode        <= rst_n & (mode == MODE_SERIAL);
   end

   // ------------------------------------------------------------
   // register port
   // ------------------------------------------------------------
   logic [BUS_DATA_BITS-1:0] next_rdata;
   logic [BUS_DATA_BITS-1:0] status_word;

   always_comb begin
      status_word               = '0;
      status_word[ST_SERIAL_BIT] = serial_mode;
      status_word[ST_FMT_BIT]   = ctrl.format_invert;
      status_word[ST_OEA_BIT]   = data_a_oe_n;
      status_word[ST_OEB_BIT]   = data_b_oe_n;
      status_word[ST_PD_BIT]    = power_down;
      status_word[ST_REF_BIT]   = internal_reference;
      status_word[ST_RANGE_A_BIT] = over_range_flag_a;
      status_word[ST_RANGE_B_BIT] = over_range_flag_b;
      next_force_pd = force_pd;
      next_rdata    = '0;
      if (bus_write && bus_addr == CONTROL_ADDR) begin
         next_force_pd = bus_wdata[CTRL_FORCE_PD_BIT];
      end
      if (bus_read && bus_addr == STATUS_ADDR) begin
         next_rdata = status_word;
      end else if (bus_read && bus_addr == CONTROL_ADDR) begin
         next_rdata[CTRL_FORCE_PD_BIT] = force_pd;
      end
      if (!rst_n) begin
         next_force_pd = CONTROL_RESET;
         next_rdata    = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      force_pd  <= next_force_pd;
      bus_rdata <= next_rdata;
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   mode_select_a: assert property (
      !sync_pins.mode_select ##1 1 |=> !serial_mode)
      else $error("serial mode shown with select low");

   serial_on_a: assert property (
      sync_pins.mode_select [*2] |=> serial_mode)
      else $error("serial mode not shown with select high");

   serial_reset_a: assert property (
      !sync_pins.mode_select |=> ser_regs[SER_CTRL_ADDR] == SER_REG_RESET)
      else $error("serial register not reset by select");

   no_early_write_a: assert property (
      !sync_pins.mode_select && sync_toggle != toggle_seen
      |=> toggle_seen == $past(sync_toggle) && ser_ctrl == SER_REG_RESET)
      else $error("serial write taken while select low");

   format_twos_a: assert property (
      mode == MODE_DIRECT && sync_pins.shared_a && !pd_eff
      |=> data_a[SAMPLE_BITS-1] == !$past(sample_a[SAMPLE_BITS-1])
          && data_b[SAMPLE_BITS-2:0] == $past(sample_b[SAMPLE_BITS-2:0]))
      else $error("two's complement format wrong");

   oe_channels_a: assert property (
      rst_n && mode == MODE_DIRECT |=> data_a_oe_n == $past(sync_pins.shared_b)
                                       && data_b_oe_n == $past(sync_pins.out_enable_b_n, 1))
      else $error("output enable not following its pin");

   power_down_a: assert property (
      mode == MODE_DIRECT && sync_pins.shared_c |=> power_down && data_a == '0)
      else $error("power-down request not obeyed");

   reference_sel_a: assert property (
      ##1 internal_reference == $past(sync_pins.reference_source_select))
      else $error("reference select not following its pin");

   over_range_a: assert property (
      rst_n && !pd_eff |=> over_range_flag_a == $past(over_range_raw_a)
                           && over_range_flag_b == $past(over_range_raw_b))
      else $error("over-range flag missed");
endmodule

// ==== adc_control_pin_decode_test.sv ====
// self-checking bench for the control pin decoder
`timescale 1ns/100ps
module adc_control_pin_decode_test;
   import adc_pin_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic                     sys_clk = 1'b0;
   logic                     rst_n = 1'b0;
   pins_s                    pins;
   logic [SAMPLE_BITS-1:0]   sample_a = 12'h2a5;
   logic [SAMPLE_BITS-1:0]   sample_b = 12'h5c3;
   logic                     over_range_raw_a = 1'b0;
   logic                     over_range_raw_b = 1'b0;
   logic [BUS_ADDR_BITS-1:0] bus_addr = 8'h00;
   logic [BUS_DATA_BITS-1:0] bus_wdata = 32'h0;
   logic                     bus_write = 1'b0;
   logic                     bus_read = 1'b0;
   logic [BUS_DATA_BITS-1:0] bus_rdata;
   logic [SAMPLE_BITS-1:0]   data_a;
   logic [SAMPLE_BITS-1:0]   data_b;
   logic                     data_a_oe_n;
   logic                     data_b_oe_n;
   logic                     power_down;
   logic                     internal_reference;
   logic                     over_range_flag_a;
   logic                     over_range_flag_b;
   logic                     serial_mode;
   logic [31:0]              rd;
   int                       n_mismatch = 0;
   int                       check_count = 0;
   int                       cycles = 0;

   always #50 sys_clk = ~sys_clk;

   host_pin_driver i_host_pin_driver (.pins(pins));

   adc_control_pin_decode i_adc_control_pin_decode (
      .sys_clk(sys_clk), .rst_n(rst_n), .serial_write_clock(pins.shared_b), .pins(pins),
      .sample_a(sample_a), .sample_b(sample_b), .over_range_raw_a(over_range_raw_a),
      .over_range_raw_b(over_range_raw_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .data_a(data_a),
      .data_a_oe_n(data_a_oe_n), .data_b(data_b), .data_b_oe_n(data_b_oe_n),
      .power_down(power_down), .internal_reference(internal_reference),
      .over_range_flag_a(over_range_flag_a), .over_range_flag_b(over_range_flag_b),
      .serial_mode(serial_mode));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic report_and_stop();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] expected);
      check_count++;
      if (seen !== expected) begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, expected);
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus_write <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge sys_clk);
      bus_write <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      bus_read <= 1'b1;
      bus_addr <= a;
      @(posedge sys_clk);
      bus_read <= 1'b0;
      #1;
      d = bus_rdata;
   endtask

   // pins need 3 edges, select 4 to reach serial_mode; serial words a few more after the toggle
   task automatic settle();
      repeat (8) @(posedge sys_clk);
      #1;
   endtask

   task automatic check_outputs(input logic fmt, oea, pd, oeb, ref_int, ra, rb, ser);
      logic [11:0] fa;
      logic [11:0] fb;
      logic [31:0] st;
      fa = pd ? 12'h000 : (fmt ? sample_a ^ 12'h800 : sample_a);
      fb = pd ? 12'h000 : (fmt ? sample_b ^ 12'h800 : sample_b);
      check(data_a, fa);
      check(data_b, fb);
      check(data_a_oe_n, oea);
      check(data_b_oe_n, oeb);
      check(power_down, pd);
      check(internal_reference, ref_int);
      check(over_range_flag_a, ra & ~pd);
      check(over_range_flag_b, rb & ~pd);
      check(serial_mode, ser);
      st = {24'h0, rb & ~pd, ra & ~pd, ref_int, pd, oeb, oea, fmt, ser};
      bus_rd(STATUS_ADDR, rd);
      check(rd, st);
   endtask

   // ------------------------------------------------------------
   // hang guard and main sequence
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         i_host_pin_driver.set_direct(i[4:0]);
         @(posedge sys_clk);
         over_range_raw_a <= i[1];
         over_range_raw_b <= ~i[0];
         settle();
         check_outputs(i[0], i[1], i[2], i[3], i[4], i[1], ~i[0], 1'b0);
      end
      i_host_pin_driver.set_direct(5'h00);
      bus_wr(CONTROL_ADDR, 32'h1);
      bus_rd(CONTROL_ADDR, rd);
      check(rd, 32'h1);
      bus_wr(8'h08, 32'hffff_ffff);
      bus_wr(STATUS_ADDR, 32'hffff_ffff);
      bus_rd(8'h08, rd);
      check(rd, 32'h0);
      settle();
      check_outputs(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      bus_wr(CONTROL_ADDR, 32'h0);
      bus_rd(CONTROL_ADDR, rd);
      check(rd, 32'h0);
      // serial mode: shared pins idle at levels that would mean power-down in direct mode
      i_host_pin_driver.select_low();
      settle();
      i_host_pin_driver.select_high();
      settle();
      check_outputs(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      i_host_pin_driver.serial_word({SER_CTRL_ADDR, 12'h003}, 16);
      settle();
      check_outputs(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      // a frame cut short must leave the registers alone
      i_host_pin_driver.serial_word({SER_CTRL_ADDR, 12'h004}, 8);
      settle();
      check_outputs(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      i_host_pin_driver.serial_word({SER_CTRL_ADDR, 12'h004}, 16);
      settle();
      check_outputs(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      i_host_pin_driver.select_low();
      settle();
      check_outputs(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      i_host_pin_driver.select_high();
      settle();
      check_outputs(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      report_and_stop();
   end
endmodule

// ==== adc_pin_pkg.sv ====
// constants and carrier types for the control pin decoder
package adc_pin_pkg;
   // ------------------------------------------------------------
   // data path
   // ------------------------------------------------------------
   localparam int SAMPLE_BITS = 12;

   // ------------------------------------------------------------
   // serial port framing and serial register file
   // ------------------------------------------------------------
   localparam int SER_WORD_BITS = 16;
   localparam int SER_ADDR_BITS = 4;
   localparam int SER_DATA_BITS = 12;
   localparam int SER_REG_COUNT = 16;
   localparam logic [3:0] SER_LAST_BIT = 4'hf;
   localparam logic [SER_ADDR_BITS-1:0] SER_CTRL_ADDR = 4'h0;
   localparam logic [SER_DATA_BITS-1:0] SER_REG_RESET = 12'h000;
   localparam int SER_FMT_BIT = 0;
   localparam int SER_OEA_BIT = 1;
   localparam int SER_PD_BIT = 2;

   // ------------------------------------------------------------
   // register port
   // ------------------------------------------------------------
   localparam int BUS_ADDR_BITS = 8;
   localparam int BUS_DATA_BITS = 32;
   localparam logic [BUS_ADDR_BITS-1:0] STATUS_ADDR = 8'h00;
   localparam logic [BUS_ADDR_BITS-1:0] CONTROL_ADDR = 8'h04;
   localparam logic CONTROL_RESET = 1'b0;
   localparam int CTRL_FORCE_PD_BIT = 0;
   localparam int ST_SERIAL_BIT = 0;
   localparam int ST_FMT_BIT = 1;
   localparam int ST_OEA_BIT = 2;
   localparam int ST_OEB_BIT = 3;
   localparam int ST_PD_BIT = 4;
   localparam int ST_REF_BIT = 5;
   localparam int ST_RANGE_A_BIT = 6;
   localparam int ST_RANGE_B_BIT = 7;

   typedef enum logic {MODE_DIRECT, MODE_SERIAL} port_mode_e;

   // control pins as they arrive at the package
   typedef struct packed {
      logic mode_select;
      logic shared_a;          // format_invert / serial_write_enable_n
      logic shared_b;          // out_enable_a_n / serial write clock level
      logic shared_c;          // power_down_request / serial_write_data
      logic out_enable_b_n;
      logic reference_source_select;
   } pins_s;

   typedef struct packed {
      logic format_invert;
      logic out_enable_a_n;
      logic power_down_request;
   } controls_s;
endpackage

// ==== host_pin_driver.sv ====
// host model driving the converter's control pins and serial write port
`timescale 1ns/100ps
module host_pin_driver (
   output adc_pin_pkg::pins_s pins
);
   import adc_pin_pkg::*;
   // ------------------------------------------------------------
   // pin levels and link timing
   // ------------------------------------------------------------
   localparam realtime HALF_LINK = 62.5;

   // select must really fall once: with the link clock still, the serial side clears only on its edge
   initial begin
      pins = '0;
      pins.mode_select = 1'b1;
      #10;
      pins.mode_select = 1'b0;
   end

   // ------------------------------------------------------------
   // host operations
   // ------------------------------------------------------------
   // bits: 0 format, 1 channel A enable_n, 2 power-down, 3 channel B enable_n, 4 reference
   task automatic set_direct(input logic [4:0] v);
      pins.shared_a = v[0];
      pins.shared_b = v[1];
      pins.shared_c = v[2];
      pins.out_enable_b_n = v[3];
      pins.reference_source_select = v[4];
   endtask

   // select low also clears the serial registers; shared pins parked at direct defaults
   task automatic select_low();
      pins.mode_select = 1'b0;
      pins.shared_a = 1'b0;
      pins.shared_b = 1'b0;
      pins.shared_c = 1'b0;
   endtask

   // idle serial levels chosen so that a direct-mode reading would show power-down
   task automatic select_high();
      pins.shared_a = 1'b1;
      pins.shared_c = 1'b1;
      pins.mode_select = 1'b1;
   endtask

   // link clock stands low outside frames; msb first
   task automatic serial_word(input logic [15:0] w, input int nbits);
      pins.shared_a = 1'b0;
      #(HALF_LINK);
      for (int i = 15; i > 15 - nbits; i--) begin
         pins.shared_c = w[i];
         #(HALF_LINK);
         pins.shared_b = 1'b1;
         #(HALF_LINK);
         pins.shared_b = 1'b0;
      end
      #(HALF_LINK);
      pins.shared_a = 1'b1;
      pins.shared_c = ~pins.shared_c;
   endtask
endmodule

// ==== pin_sync.sv ====
// two flip-flop synchroniser for pins and cross-domain levels
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync;

   always_comb begin
      next_stage1 = async_in;
      next_sync   = stage1;
      if (!rst_n) begin
         next_stage1 = '0;
         next_sync   = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      stage1   <= next_stage1;
      sync_out <= next_sync;
   end
endmodule

// ==== serial_shift_in.sv ====
// serial write port: shifts words in on the serial write clock
`timescale 1ns/100ps
module serial_shift_in (
   input  wire logic                                serial_write_clock,
   input  wire logic                                mode_select,
   input  wire logic                                serial_write_enable_n,
   input  wire logic                                serial_write_data,
   output logic      [adc_pin_pkg::SER_WORD_BITS-1:0] word,
   output logic                                     word_toggle
);
   import adc_pin_pkg::*;

   logic                     frame_reset;
   logic [3:0]               bit_count;
   logic [3:0]               next_bit_count;
   logic [SER_WORD_BITS-1:0] shift;
   logic [SER_WORD_BITS-1:0] next_shift;
   logic [SER_WORD_BITS-1:0] next_word;
   logic                     next_toggle;

   // the clock stands still between frames, so the frame itself clears the counter
   assign frame_reset = serial_write_enable_n | ~mode_select;

   always_comb begin
      next_shift     = {shift[SER_WORD_BITS-2:0], serial_write_data};
      next_bit_count = bit_count + 4'h1;
      next_word      = word;
      next_toggle    = word_toggle;
      if (bit_count == SER_LAST_BIT) begin
         next_word   = next_shift;
         next_toggle = ~word_toggle;
      end
   end

   always_ff @(posedge serial_write_clock or posedge frame_reset) begin
      if (frame_reset) begin
         bit_count <= 4'h0;
         shift     <= '0;
      end else begin
         bit_count <= next_bit_count;
         shift     <= next_shift;
      end
   end

   // select low clears the hand-over too
   always_ff @(posedge serial_write_clock or negedge mode_select) begin
      if (!mode_select) begin
         word        <= '0;
         word_toggle <= 1'b0;
      end else begin
         word        <= next_word;
         word_toggle <= next_toggle;
      end
   end
endmodule
